// ---- core/rpfr_defs.svh ----
`ifndef RPFR_DEFS_SVH
`define RPFR_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RPFR_OFS_CTRL      8'h00
`define RPFR_OFS_CMD_STAT  8'h04
`define RPFR_OFS_CMD_LEN   8'h08
`define RPFR_OFS_CMD_DATA  8'h0c
`define RPFR_OFS_RSP_DATA  8'h10
`define RPFR_OFS_RSP_CTRL  8'h14
`define RPFR_OFS_STATUS    8'h18

// ----------------------------------------
// field positions, reset value and busy byte
// ----------------------------------------
`define RPFR_CTRL_I2C_BIT  0
`define RPFR_STAT_VAL_BIT  0
`define RPFR_RSPC_VAR_BIT  8
`define RPFR_RSPC_GO_BIT   9
`define RPFR_CTRL_RST      1'b0
`define RPFR_BUSY_BYTE     8'h80

// ----------------------------------------
// packet limits
// ----------------------------------------
`define RPFR_MAX_PKT       16'h0200
`define RPFR_BUF_DEPTH     512

// ----------------------------------------
// timing
// ----------------------------------------
`define RPFR_CLK_HZ        50000000
`define RPFR_RESYNC_MS     750
`define RPFR_RESYNC_CYC    ((`RPFR_CLK_HZ / 1000) * `RPFR_RESYNC_MS)

`endif

// ---- core/rpfr_pkg.sv ----
package rpfr_pkg;

    typedef enum logic [3:0] {
        P_HDR  = 4'h0,
        P_OPC  = 4'h1,
        P_L0   = 4'h2,
        P_L1   = 4'h3,
        P_DAT  = 4'h4,
        P_CHK  = 4'h5,
        P_HOLD = 4'h6,
        P_SKIP = 4'h7
    } rpfr_pst_e;

    typedef enum logic [2:0] {
        T_IDLE = 3'h0,
        T_HDR  = 3'h1,
        T_L0   = 3'h2,
        T_L1   = 3'h3,
        T_DAT  = 3'h4,
        T_CHK  = 3'h5
    } rpfr_tst_e;

    typedef enum logic [7:0] {
        E_NONE      = 8'h00,
        E_DEST      = 8'h01,
        E_CMD       = 8'h02,
        E_LEN       = 8'h03,
        E_BUF_SMALL = 8'h04,
        E_LEN_MISS  = 8'h05,
        E_CHKSUM    = 8'h06,
        E_TIMEOUT   = 8'h07,
        E_RD_UNSUP  = 8'h08,
        E_WR_UNSUP  = 8'h09,
        E_EXEC      = 8'h0a,
        E_RSP_LEN   = 8'h0b,
        E_BUF_FULL  = 8'h0c
    } rpfr_err_e;

    typedef struct packed {
        logic       rd;
        logic       reply;
        logic       chk;
        logic       len;
        logic       oplen;
        logic [2:0] dest;
    } rpfr_cmd_hdr_s;

    typedef struct packed {
        logic       busy;
        logic       err;
        logic       chk;
        logic       len;
        logic       rsvd;
        logic [2:0] dest;
    } rpfr_rsp_hdr_s;

    typedef struct packed {
        logic       start;
        logic [7:0] data;
    } rpfr_rx_ent_s;

endpackage

// ---- core/rpfr_top.sv ----
`timescale 1ns/1ns
`include "rpfr_defs.svh"
module rpfr_top #(
    parameter int unsigned RESYNC_CYC = `RPFR_RESYNC_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // command link pins
    input  wire logic        link_clk,
    input  wire logic        link_grp,
    input  wire logic        link_dat,
    // response byte stream
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data
);
    import rpfr_pkg::*;

    // ----------------------------------------
    // link synchronisers and bit shifter
    // ----------------------------------------
    logic [2:0]  clk_s_reg;
    logic [2:0]  grp_s_reg;
    logic [1:0]  dat_s_reg;
    logic [7:0]  sh_reg;
    logic [2:0]  bit_cnt_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_s_reg <= 3'h0;
            grp_s_reg <= 3'h0;
            dat_s_reg <= 2'h0;
        end else begin
            clk_s_reg <= {clk_s_reg[1:0], link_clk};
            grp_s_reg <= {grp_s_reg[1:0], link_grp};
            dat_s_reg <= {dat_s_reg[0], link_dat};
        end
    end

    wire       grp_on   = grp_s_reg[1];
    wire       grp_rise = grp_s_reg[1] & ~grp_s_reg[2];
    wire       bit_take = clk_s_reg[1] & ~clk_s_reg[2] & grp_on;
    wire       byte_in  = bit_take & (bit_cnt_reg == 3'h7);
    wire [7:0] byte_val = {sh_reg[6:0], dat_s_reg[1]};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sh_reg      <= 8'h00;
            bit_cnt_reg <= 3'h0;
        end else if (!grp_on) begin
            bit_cnt_reg <= 3'h0;
        end else if (bit_take) begin
            sh_reg      <= byte_val;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // ----------------------------------------
    // resync gap timer
    // ----------------------------------------
    logic [31:0] gap_reg;
    logic        first_reg;
    logic        start_reg;
    wire         gap_over = (gap_reg >= RESYNC_CYC);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gap_reg   <= 32'h0000_0000;
            first_reg <= 1'b1;
            start_reg <= 1'b0;
        end else begin
            if (byte_in)
                gap_reg <= 32'h0000_0000;
            else if (!gap_over)
                gap_reg <= gap_reg + 32'h0000_0001;
            if (grp_rise && (gap_over || first_reg))
                start_reg <= 1'b1;
            else if (byte_in)
                start_reg <= 1'b0;
            if (byte_in)
                first_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // receive byte queue
    // ----------------------------------------
    rpfr_rx_ent_s rx_mem [`RPFR_BUF_DEPTH];
    logic [9:0]   wr_ptr_reg;
    logic [9:0]   rd_ptr_reg;
    wire  [9:0]   fill  = wr_ptr_reg - rd_ptr_reg;
    wire          full  = (fill == 10'h200);
    wire          empty = (fill == 10'h000);
    wire          push  = byte_in & ~full;

    always_ff @(posedge sys_clk) begin
        if (push)
            rx_mem[wr_ptr_reg[8:0]] <= '{start: start_reg | (byte_in & grp_rise), data: byte_val};
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            wr_ptr_reg <= 10'h000;
        else if (push)
            wr_ptr_reg <= wr_ptr_reg + 10'h001;
    end

    // ----------------------------------------
    // command parser
    // ----------------------------------------
    rpfr_pst_e     pst_reg;
    rpfr_pst_e     pnx;
    rpfr_err_e     perr;
    rpfr_cmd_hdr_s hdr_reg;
    logic [7:0]    opc_reg;
    logic [15:0]   len_reg;
    logic [9:0]    cnt_reg;
    logic [15:0]   rs1_reg;
    logic [15:0]   rs2_reg;
    logic [7:0]    cmd_mem [`RPFR_BUF_DEPTH];
    logic          consume;

    rpfr_rx_ent_s  ent;
    assign ent = rx_mem[rd_ptr_reg[8:0]];
    wire        pop      = ~empty & (pst_reg != P_HOLD);
    wire [7:0]  b        = ent.data;
    wire        is_start = ent.start;
    wire [3:0]  pcur     = is_start ? P_HDR : pst_reg;
    wire [15:0] rs1n     = (pcur == P_HDR) ? {8'h00, b} : rs1_reg + {8'h00, b};
    wire [15:0] rs2n     = (pcur == P_HDR) ? {8'h00, b} : rs2_reg + rs1n;
    wire [15:0] len_full = {b, len_reg[7:0]};
    wire [15:0] len_lim  = `RPFR_MAX_PKT - 16'h0004 - {15'h0000, hdr_reg.chk};
    wire        want_rsp = hdr_reg.rd | hdr_reg.reply;
    wire        chk_next = hdr_reg.chk;

    always_comb begin
        pnx  = pst_reg;
        perr = E_NONE;
        case (pcur)
            P_HDR:  pnx = P_OPC;
            P_OPC:  pnx = hdr_reg.len ? P_L0 : (chk_next ? P_CHK : P_HOLD);
            P_L0:   pnx = P_L1;
            P_L1: begin
                if (len_full > len_lim) begin
                    perr = E_BUF_SMALL;
                    pnx  = P_SKIP;
                end else if (len_full == 16'h0000) begin
                    pnx = chk_next ? P_CHK : P_HOLD;
                end else begin
                    pnx = P_DAT;
                end
            end
            P_DAT: begin
                if (cnt_reg == len_reg[9:0] - 10'h001)
                    pnx = chk_next ? P_CHK : P_HOLD;
            end
            P_CHK: begin
                if (b != rs2_reg[7:0]) begin
                    perr = E_CHKSUM;
                    pnx  = P_SKIP;
                end else begin
                    pnx = P_HOLD;
                end
            end
            P_SKIP: pnx = P_SKIP;
            default: pnx = P_HDR;
        endcase
    end

    wire auto_go = pop & (perr != E_NONE) & want_rsp;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pst_reg    <= P_HDR;
            rd_ptr_reg <= 10'h000;
            hdr_reg    <= '0;
            opc_reg    <= 8'h00;
            len_reg    <= 16'h0000;
            cnt_reg    <= 10'h000;
            rs1_reg    <= 16'h0000;
            rs2_reg    <= 16'h0000;
        end else begin
            if (pop) begin
                pst_reg    <= pnx;
                rs1_reg    <= rs1n;
                rs2_reg    <= rs2n;
                rd_ptr_reg <= rd_ptr_reg + 10'h001;
            end else if (pst_reg == P_HOLD && consume) begin
                pst_reg <= P_HDR;
            end
            if (pop && pcur == P_HDR) begin
                hdr_reg <= b;
                len_reg <= 16'h0000;
                cnt_reg <= 10'h000;
            end
            if (pop && pcur == P_OPC)
                opc_reg <= b;
            if (pop && pcur == P_L0)
                len_reg[7:0] <= b;
            if (pop && pcur == P_L1)
                len_reg[15:8] <= b;
            if (pop && pcur == P_DAT)
                cnt_reg <= cnt_reg + 10'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (pop && pcur == P_DAT)
            cmd_mem[cnt_reg[8:0]] <= b;
    end

    // ----------------------------------------
    // wishbone decode
    // ----------------------------------------
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic        i2c_reg;
    logic [9:0]  rix_reg;
    logic [7:0]  rsp_mem [`RPFR_BUF_DEPTH];
    logic [9:0]  rsp_cnt_reg;
    logic [7:0]  last_err_reg;
    rpfr_tst_e   tst_reg;

    wire acc     = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wr      = acc & wb_we_i;
    wire rd      = acc & ~wb_we_i;
    wire s_ctrl  = (wb_adr_i == `RPFR_OFS_CTRL);
    wire s_cstat = (wb_adr_i == `RPFR_OFS_CMD_STAT);
    wire s_clen  = (wb_adr_i == `RPFR_OFS_CMD_LEN);
    wire s_cdat  = (wb_adr_i == `RPFR_OFS_CMD_DATA);
    wire s_rdat  = (wb_adr_i == `RPFR_OFS_RSP_DATA);
    wire s_rctl  = (wb_adr_i == `RPFR_OFS_RSP_CTRL);
    wire s_stat  = (wb_adr_i == `RPFR_OFS_STATUS);
    wire cmd_val = (pst_reg == P_HOLD);

    assign consume = wr & s_cstat & wb_sel_i[0] & wb_dat_i[`RPFR_STAT_VAL_BIT];
    wire   rsp_put = wr & s_rdat & wb_sel_i[0];
    wire   sw_go   = wr & s_rctl & wb_sel_i[1] & wb_dat_i[`RPFR_RSPC_GO_BIT];
    wire   sw_var  = wb_dat_i[`RPFR_RSPC_VAR_BIT];
    wire   fire_sw = sw_go & want_rsp;

    wire [31:0] rd_mux =
        s_ctrl  ? {31'h0000_0000, i2c_reg} :
        s_cstat ? {8'h00, opc_reg, hdr_reg, 7'h00, cmd_val} :
        s_clen  ? {16'h0000, len_reg} :
        s_cdat  ? {24'h00_0000, cmd_mem[rix_reg[8:0]]} :
        s_rdat  ? {22'h00_0000, rsp_cnt_reg} :
        s_rctl  ? {31'h0000_0000, tst_reg != T_IDLE} :
        s_stat  ? {24'h00_0000, last_err_reg} : 32'h0000_0000;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            i2c_reg <= `RPFR_CTRL_RST;
            rix_reg <= 10'h000;
        end else begin
            ack_reg <= acc;
            if (rd)
                dat_reg <= rd_mux;
            if (wr && s_ctrl && wb_sel_i[0])
                i2c_reg <= wb_dat_i[`RPFR_CTRL_I2C_BIT];
            if (consume)
                rix_reg <= 10'h000;
            else if (rd && s_cdat)
                rix_reg <= rix_reg + 10'h001;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ----------------------------------------
    // response buffer and error latch
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rsp_put && rsp_cnt_reg < 10'h200)
            rsp_mem[rsp_cnt_reg[8:0]] <= wb_dat_i[7:0];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rsp_cnt_reg  <= 10'h000;
            last_err_reg <= E_NONE;
        end else begin
            if (sw_go)
                rsp_cnt_reg <= 10'h000;
            else if (rsp_put && rsp_cnt_reg < 10'h200)
                rsp_cnt_reg <= rsp_cnt_reg + 10'h001;
            if (byte_in && full)
                last_err_reg <= E_BUF_FULL;
            else if (pop && perr != E_NONE)
                last_err_reg <= perr;
        end
    end

    // ----------------------------------------
    // response framer
    // ----------------------------------------
    logic [9:0]  tidx_reg;
    logic [9:0]  tlen_reg;
    logic [7:0]  terr_reg;
    logic        tlp_reg;
    logic        tcp_reg;
    logic [15:0] ts1_reg;
    logic [15:0] ts2_reg;
    logic        tv_reg;
    logic [7:0]  td_reg;
    rpfr_tst_e   tnx;

    wire [7:0]  go_err  = auto_go ? perr : wb_dat_i[7:0];
    wire        go_lp   = hdr_reg.len | (~auto_go & sw_var);
    wire        go_e    = (go_err != E_NONE);
    wire [9:0]  go_len0 = go_e ? 10'h001 : rsp_cnt_reg;
    wire [11:0] go_tot  = 12'h001 + {1'b0, go_lp, 1'b0} + {2'h0, go_len0} + {11'h000, hdr_reg.chk};
    wire        go_ovr  = (go_tot > `RPFR_MAX_PKT);
    wire [7:0]  go_code = go_ovr ? E_RSP_LEN : go_err;
    wire [9:0]  go_len  = go_ovr ? 10'h001 : go_len0;
    wire        go_fire = auto_go | fire_sw;

    rpfr_rsp_hdr_s go_hdr;
    assign go_hdr = '{busy: 1'b0, err: go_code != E_NONE, chk: hdr_reg.chk,
                      len: go_lp, rsvd: 1'b0, dest: hdr_reg.dest};

    wire        take  = tv_reg & tx_ready;
    wire [15:0] ts1n  = (tst_reg == T_HDR) ? {8'h00, td_reg} : ts1_reg + {8'h00, td_reg};
    wire [15:0] ts2n  = (tst_reg == T_HDR) ? {8'h00, td_reg} : ts2_reg + ts1n;
    wire [9:0]  tidxn = (tst_reg == T_DAT) ? tidx_reg + 10'h001 : 10'h000;
    wire        has_d = (tlen_reg != 10'h000);

    always_comb begin
        tnx = T_IDLE;
        case (tst_reg)
            T_HDR:  tnx = tlp_reg ? T_L0 : (has_d ? T_DAT : (tcp_reg ? T_CHK : T_IDLE));
            T_L0:   tnx = T_L1;
            T_L1:   tnx = has_d ? T_DAT : (tcp_reg ? T_CHK : T_IDLE);
            T_DAT:  tnx = (tidx_reg == tlen_reg - 10'h001) ? (tcp_reg ? T_CHK : T_IDLE) : T_DAT;
            T_CHK:  tnx = T_IDLE;
            default: tnx = T_IDLE;
        endcase
    end

    wire [7:0] dat_b  = (terr_reg != E_NONE) ? terr_reg : rsp_mem[tidxn[8:0]];
    wire [7:0] next_b = (tnx == T_L0)  ? tlen_reg[7:0] :
                        (tnx == T_L1)  ? {6'h00, tlen_reg[9:8]} :
                        (tnx == T_DAT) ? dat_b :
                        (tnx == T_CHK) ? ts2n[7:0] : 8'h00;
    wire busy_now = i2c_reg & (~empty | (pst_reg != P_HDR && pst_reg != P_SKIP));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tst_reg  <= T_IDLE;
            tv_reg   <= 1'b0;
            td_reg   <= 8'h00;
            tidx_reg <= 10'h000;
            tlen_reg <= 10'h000;
            terr_reg <= E_NONE;
            tlp_reg  <= 1'b0;
            tcp_reg  <= 1'b0;
            ts1_reg  <= 16'h0000;
            ts2_reg  <= 16'h0000;
        end else if (push) begin
            tst_reg <= T_IDLE;
            tv_reg  <= 1'b0;
        end else if (go_fire) begin
            tst_reg  <= T_HDR;
            tv_reg   <= 1'b1;
            td_reg   <= go_hdr;
            tlen_reg <= go_len;
            terr_reg <= go_code;
            tlp_reg  <= go_lp;
            tcp_reg  <= hdr_reg.chk;
        end else if (tst_reg != T_IDLE) begin
            if (take) begin
                tst_reg  <= tnx;
                tv_reg   <= (tnx != T_IDLE);
                td_reg   <= next_b;
                tidx_reg <= tidxn;
                ts1_reg  <= ts1n;
                ts2_reg  <= ts2n;
            end
        end else begin
            tv_reg <= busy_now;
            td_reg <= `RPFR_BUSY_BYTE;
        end
    end

    assign tx_valid = tv_reg;
    assign tx_data  = td_reg;

endmodule

// ---- sim/rpfr_top_sva.sv ----
`timescale 1ns/1ns
module rpfr_top_sva #(
    parameter int unsigned RESYNC_CYC = 200
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // command link pins
    input wire logic        link_clk,
    input wire logic        link_grp,
    input wire logic        link_dat,
    // response byte stream
    input wire logic        tx_ready,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data
);
    import rpfr_pkg::*;
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    logic [7:0] quiet_cnt;
    logic [3:0] ack_age;
    logic       ctrl_shadow;
    wire        taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            quiet_cnt   <= 8'h00;
            ack_age     <= 4'h0;
            ctrl_shadow <= 1'b0;
        end else begin
            quiet_cnt <= link_grp ? 8'h00 : quiet_cnt + {7'h0, quiet_cnt != 8'hff};
            ack_age   <= wb_ack_o ? 4'h0 : ack_age + {3'h0, ack_age != 4'hf};
            if (taken && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0])
                ctrl_shadow <= wb_dat_i[0];
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_prompt: assert property (taken |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(taken))
        else $error("ack without request");
    a_reset_idle: assert property ($past(rst) |-> !wb_ack_o && !tx_valid && tx_data == 8'h00 && wb_dat_o == 32'h0)
        else $error("outputs not idle after reset");
    a_unmapped_zero: assert property (taken && !wb_we_i && wb_adr_i > 8'h18 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (taken && !wb_we_i && wb_adr_i == 8'h00 |=> wb_dat_o[0] == ctrl_shadow)
        else $error("mode bit readback wrong");
    a_tx_byte_holds: assert property (tx_valid && !tx_ready && !(wb_cyc_i && wb_stb_i) && quiet_cnt > 8'h10
        && ack_age > 4'h8 |=> tx_valid && $stable(tx_data))
        else $error("offered byte changed before take");
    a_tx_has_cause: assert property ($rose(tx_valid) |-> wb_ack_o || ack_age < 4'h8 || quiet_cnt < 8'h40)
        else $error("response started without cause");
    c_take: cover property (tx_valid && tx_ready);
    c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
    c_go: cover property (taken && wb_we_i && wb_adr_i == 8'h14);
endmodule
bind rpfr_top rpfr_top_sva #(.RESYNC_CYC(RESYNC_CYC)) i_sva (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .link_clk(link_clk), .link_grp(link_grp), .link_dat(link_dat), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data)
);

// ---- sim/rpfr_host_model.sv ----
`timescale 1ns/1ns
module rpfr_host_model (
    // link pins toward the device
    output logic link_clk,
    output logic link_grp,
    output logic link_dat
);
    initial begin
        link_clk = 1'b0;
        link_grp = 1'b0;
        link_dat = 1'b1;
    end
    // one byte group, msb first, clock still outside the group
    task automatic send(input logic [7:0] b[$]);
        #7;
        link_grp = 1'b1;
        foreach (b[i]) begin
            for (int k = 7; k >= 0; k--) begin
                link_dat = b[i][k];
                #40 link_clk = 1'b1;
                #80 link_clk = 1'b0;
                #40;
            end
        end
        link_grp = 1'b0;
        link_dat = ~link_dat;
    endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import rpfr_pkg::*;
    localparam int unsigned RS = 200;
    typedef struct {
        logic [7:0] hdr;
        int         ndat;
        int         nrsp;
        logic       vsz;
        logic [7:0] err;
    } rpfr_tb_row_s;
    logic        sys_clk;
    logic        rst = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'hf;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        link_clk;
    logic        link_grp;
    logic        link_dat;
    logic        tx_ready = 1'b0;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        stall = 1'b0;
    logic        hold_off = 1'b0;
    logic [31:0] rd;
    logic [7:0]  pkt [$];
    logic [7:0]  exp_q [$];
    logic [7:0]  rx_q [$];
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cyc_cnt = 0;
    rpfr_tb_row_s rows [5] = '{'{8'hb3, 2, 2, 1'b0, 8'h00}, '{8'h01, 0, 0, 1'b0, 8'h00},
        '{8'h52, 3, 0, 1'b0, 8'h00}, '{8'h84, 0, 1, 1'b1, 8'h00}, '{8'h77, 1, 0, 1'b0, 8'h0a}};
    rpfr_top #(.RESYNC_CYC(RS)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .link_clk(link_clk), .link_grp(link_grp), .link_dat(link_dat), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data));
    rpfr_host_model i_host (.link_clk(link_clk), .link_grp(link_grp), .link_dat(link_dat));
    // ----------------------------------------
    // clock, sink, monitor, timeout
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        tx_ready <= hold_off ? 1'b0 : (stall ? ~tx_ready : 1'b1);
        if (tx_valid === 1'b1 && tx_ready === 1'b1) rx_q.push_back(tx_data);
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 60000) begin
            mismatches++;
            results();
        end
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] sum_chk(input logic [7:0] q[$]);
        logic [15:0] s1;
        logic [15:0] s2;
        s1 = 16'h0;
        s2 = 16'h0;
        foreach (q[i]) begin
            s1 = s1 + {8'h00, q[i]};
            s2 = s2 + s1;
        end
        return s2[7:0];
    endfunction
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do @(posedge sys_clk); while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wait_held(input logic [7:0] hdr, input logic [7:0] opc);
        int n = 0;
        do begin
            wb(1'b0, 8'h04, 32'h0, rd);
            n++;
        end while (rd[0] !== 1'b1 && n < 300);
        check(rd & 32'h00ff_ff01, {8'h00, opc, hdr, 8'h01});
    endtask
    task automatic send_q();
        i_host.send(pkt);
    endtask
    task automatic collect();
        int n = 0;
        while (rx_q.size() < exp_q.size() && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (12) @(posedge sys_clk);
        stall = 1'b0;
        check(32'(rx_q.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) if (i < rx_q.size()) check({24'h0, rx_q[i]}, {24'h0, exp_q[i]});
    endtask
    task automatic run(input logic [7:0] hdr, input int ndat, input int nrsp, input logic vsz, input logic [7:0] err);
        logic [7:0] opc;
        int         n;
        opc = hdr ^ 8'h5a;
        pkt = {hdr, opc};
        if (hdr[4]) pkt.push_back(ndat[7:0]);
        if (hdr[4]) pkt.push_back(ndat[15:8]);
        for (int i = 0; i < ndat; i++) pkt.push_back(8'h30 + i[7:0]);
        if (hdr[5]) pkt.push_back(sum_chk(pkt));
        send_q();
        wait_held(hdr, opc);
        wb(1'b0, 8'h08, 32'h0, rd);
        check(rd & 32'h0000_ffff, hdr[4] ? 32'(ndat) : 32'h0);
        rx_q = {};
        stall = 1'b1;
        for (int i = 0; i < nrsp; i++) wb(1'b1, 8'h10, {24'h0, 8'hc0 + i[7:0]}, rd);
        wb(1'b1, 8'h14, {22'h0, 1'b1, vsz, err}, rd);
        exp_q = {};
        n = (err != 8'h00) ? 1 : nrsp;
        if (hdr[7] || hdr[6]) exp_q.push_back({1'b0, err != 8'h00, hdr[5], hdr[4] | vsz, 1'b0, hdr[2:0]});
        if ((hdr[7] || hdr[6]) && (hdr[4] || vsz)) exp_q = {exp_q, n[7:0], n[15:8]};
        for (int i = 0; i < n && (hdr[7] || hdr[6]); i++) exp_q.push_back(err != 8'h00 ? err : 8'hc0 + i[7:0]);
        if ((hdr[7] || hdr[6]) && hdr[5]) exp_q.push_back(sum_chk(exp_q));
        collect();
        wb(1'b1, 8'h04, 32'h1, rd);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        check({30'h0, wb_ack, tx_valid}, 32'h0);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wb(1'b0, 8'h18, 32'h0, rd);
        check(rd, 32'h0);
        wb(1'b0, 8'h00, 32'h0, rd);
        check(rd, 32'h0);
        wb(1'b1, 8'h40, 32'hffff_ffff, rd);
        wb(1'b0, 8'h40, 32'h0, rd);
        check(rd, 32'h0);
        $display("test reset done");
        foreach (rows[i]) run(rows[i].hdr, rows[i].ndat, rows[i].nrsp, rows[i].vsz, rows[i].err);
        for (int e = 1; e <= 12; e++) run(8'ha6, 0, 0, 1'b0, e[7:0]);
        $display("test table done");
        pkt = {8'h01, 8'h11, 8'h02};
        send_q();
        repeat (10) @(posedge sys_clk);
        pkt = {8'h22};
        send_q();
        wait_held(8'h01, 8'h11);
        wb(1'b1, 8'h04, 32'h1, rd);
        wait_held(8'h02, 8'h22);
        wb(1'b1, 8'h04, 32'h1, rd);
        $display("test chain done");
        pkt = {8'ha1, 8'h33};
        pkt.push_back(sum_chk(pkt) + 8'h01);
        rx_q = {};
        send_q();
        exp_q = {8'h61, 8'h06};
        exp_q.push_back(sum_chk(exp_q));
        collect();
        wb(1'b0, 8'h18, 32'h0, rd);
        check(rd & 32'h0000_00ff, 32'h6);
        for (int g = 0; g < 2; g++) begin
            repeat (120) @(posedge sys_clk);
            pkt = {8'h01, 8'h44};
            send_q();
        end
        repeat (20) @(posedge sys_clk);
        wb(1'b0, 8'h04, 32'h0, rd);
        check(rd & 32'h1, 32'h0);
        repeat (RS + 40) @(posedge sys_clk);
        pkt = {8'h01, 8'h55};
        send_q();
        wait_held(8'h01, 8'h55);
        wb(1'b1, 8'h04, 32'h1, rd);
        pkt = {8'h81};
        send_q();
        repeat (RS + 40) @(posedge sys_clk);
        pkt = {8'h02, 8'h66};
        send_q();
        wait_held(8'h02, 8'h66);
        wb(1'b1, 8'h04, 32'h1, rd);
        $display("test resync done");
        wb(1'b1, 8'h00, 32'h1, rd);
        hold_off = 1'b1;
        pkt = {8'h83, 8'h77};
        send_q();
        wait_held(8'h83, 8'h77);
        repeat (3) @(posedge sys_clk);
        check({23'h0, tx_valid, tx_data}, 32'h180);
        wb(1'b1, 8'h00, 32'h0, rd);
        repeat (3) @(posedge sys_clk);
        check({31'h0, tx_valid}, 32'h0);
        wb(1'b1, 8'h14, 32'h200, rd);
        repeat (20) @(posedge sys_clk);
        check({23'h0, tx_valid, tx_data}, 32'h103);
        pkt = {8'h01, 8'h12};
        send_q();
        repeat (3) @(posedge sys_clk);
        check({31'h0, tx_valid}, 32'h0);
        hold_off = 1'b0;
        wb(1'b1, 8'h04, 32'h1, rd);
        wait_held(8'h01, 8'h12);
        wb(1'b1, 8'h04, 32'h1, rd);
        pkt = {8'h90, 8'h10, 8'h58, 8'h02};
        rx_q = {};
        send_q();
        exp_q = {8'h50, 8'h01, 8'h00, 8'h04};
        collect();
        $display("test busy and abort done");
        results();
    end
endmodule
